//--- rtl/sram_ctrl_end.sv
// Controller end: issues cycles, drains before sleep, reads only while waking
`timescale 1ns/100ps
`default_nettype none
`include "sram_cfg.svh"
module sram_ctrl_end #(
	parameter int ADDR_W = `SRAM_ADDR_W,
	parameter int DATA_W = `SRAM_DATA_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// User request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	// Sleep control
	input wire logic sleep_want,
	output logic sleep_active,
	// Link to memory
	sram_link_if.ctrl link
);
	initial begin
		if (ADDR_W != `SRAM_ADDR_W || DATA_W != `SRAM_DATA_W)
			$error("sram_ctrl_end: unsupported parameters");
	end
	typedef enum logic [1:0] {st_run, st_drain, st_sleep, st_wake} state_type;
	state_type state_reg;
	logic [1:0] pend_reg;
	logic [1:0] wake_cnt_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic issue;
	logic [1:0] rd_pend_reg;
	// Writes are refused during wake; nothing issued while draining or asleep
	assign issue = req_valid && ((state_reg == st_run && !sleep_want)
		|| (state_reg == st_wake && !req_write));
	// Sleep sequencing
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= st_run;
			wake_cnt_reg <= 2'h0;
		end else begin
			case (state_reg)
				st_run: if (sleep_want) state_reg <= st_drain;
				st_drain: if (pend_reg == 2'h0 && !issue) state_reg <= st_sleep;
				st_sleep: if (!sleep_want) begin
					state_reg <= st_wake;
					wake_cnt_reg <= 2'(`SRAM_WAKE_CYCLES);
				end
				st_wake: begin
					if (wake_cnt_reg <= 2'h1) state_reg <= st_run;
					wake_cnt_reg <= wake_cnt_reg - 2'h1;
				end
				default: state_reg <= st_run;
			endcase
		end
	end
	// Pin drive: cycle loaded with valid selects
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			link.sleep_request <= 1'b0;
			link.advance_or_load_strobe_n <= 1'b1;
			link.read_write_sel <= 1'b1;
			link.first_chip_select_n <= 1'b1;
			link.second_chip_select_n <= 1'b1;
			link.third_chip_select <= 1'b0;
			link.output_enable_n <= 1'b1;
			link.addr <= '0;
		end else begin
			link.sleep_request <= (state_reg == st_drain && pend_reg == 2'h0 && !issue)
				|| (state_reg == st_sleep && sleep_want);
			link.advance_or_load_strobe_n <= !issue;
			link.read_write_sel <= issue ? !req_write : 1'b1;
			link.first_chip_select_n <= !issue;
			link.second_chip_select_n <= !issue;
			link.third_chip_select <= issue;
			link.output_enable_n <= !(issue && !req_write);
			if (issue)
				link.addr <= req_addr;
		end
	end
	// Pending tracker: write data lags its load by one edge, so a following write
	// cannot overwrite the bus before the memory has taken the earlier word
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pend_reg <= 2'h0;
			rd_pend_reg <= 2'h0;
			wdata_reg <= '0;
			link.dq_to_mem <= '0;
			link.dq_to_mem_oe_n <= 1'b1;
		end else begin
			pend_reg <= {pend_reg[0], issue};
			rd_pend_reg <= {rd_pend_reg[0], issue && !req_write};
			if (issue && req_write)
				wdata_reg <= req_wdata;
			if (!link.advance_or_load_strobe_n && !link.read_write_sel)
				link.dq_to_mem <= wdata_reg;
			link.dq_to_mem_oe_n <= !(!link.advance_or_load_strobe_n && !link.read_write_sel);
		end
	end
	// Read data captured two edges after the load; same clock, so no sync needed
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= '0;
			rd_valid <= 1'b0;
		end else begin
			rd_data <= link.dq_from_mem;
			rd_valid <= rd_pend_reg[1] && !link.dq_from_mem_oe_n;
		end
	end
	// User-visible status
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			req_ready <= 1'b0;
			sleep_active <= 1'b0;
		end else begin
			req_ready <= (state_reg == st_run && !sleep_want);
			sleep_active <= (state_reg == st_sleep);
		end
	end
endmodule : sram_ctrl_end
`default_nettype wire

//--- rtl/sram_cfg.svh
// Constants for the synchronous memory sleep and cycle decode blocks
// Summary of operation
// - Sleep high: deselected, reduced current state
// - Sleep lasts only while pin is high (memory end keeps inputs gated two more edges through its sync)
// - In sleep ignore inputs, float data outputs
// - Sleep pin asynchronous, active high, unclocked
// - Pending operations at sleep may be lost
// - Controller drains operations before raising sleep
// - Only idle_unselected_cycle or read cycles while waking
// - Write: load strobe low, select low
// - Read: load strobe low, select high
// - Chip selects valid whenever a cycle loads
// - Address captured on load; others when enabled
// - Output enable ignored during writes
// - Sleep takes effect within one clock
// - Enabled: both selects low, third high
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH
`define SRAM_ADDR_W 17
`define SRAM_DATA_W 36
`define SRAM_CLK_PERIOD_NS 10
`define SRAM_WAKE_WINDOW_NS 10
`define SRAM_WAKE_CYCLES ((`SRAM_WAKE_WINDOW_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)
`endif

//--- rtl/sram_pkg.sv
// Cycle types used by the memory end's cycle decode
package sram_pkg;
	typedef enum logic [1:0] {
		cyc_idle_unselected,
		cyc_read,
		cyc_write
	} cycle_type;
endpackage : sram_pkg

//--- rtl/sram_link_if.sv
// Pin-level link between memory controller and synchronous memory
`timescale 1ns/100ps
`default_nettype none
`include "sram_cfg.svh"
interface sram_link_if;
	logic sleep_request;
	logic advance_or_load_strobe_n;
	logic read_write_sel;
	logic first_chip_select_n;
	logic second_chip_select_n;
	logic third_chip_select;
	logic output_enable_n;
	logic [`SRAM_ADDR_W-1:0] addr;
	logic [`SRAM_DATA_W-1:0] dq_to_mem;
	logic dq_to_mem_oe_n;
	logic [`SRAM_DATA_W-1:0] dq_from_mem;
	logic dq_from_mem_oe_n;
	modport mem (
		input sleep_request, advance_or_load_strobe_n, read_write_sel,
		input first_chip_select_n, second_chip_select_n, third_chip_select,
		input output_enable_n, addr, dq_to_mem, dq_to_mem_oe_n,
		output dq_from_mem, dq_from_mem_oe_n
	);
	modport ctrl (
		output sleep_request, advance_or_load_strobe_n, read_write_sel,
		output first_chip_select_n, second_chip_select_n, third_chip_select,
		output output_enable_n, addr, dq_to_mem, dq_to_mem_oe_n,
		input dq_from_mem, dq_from_mem_oe_n
	);
endinterface : sram_link_if
`default_nettype wire

//--- rtl/sram_mem_end.sv
// Memory end: cycle decode, flow-through array and sleep handling
`timescale 1ns/100ps
`default_nettype none
`include "sram_cfg.svh"
module sram_mem_end #(
	parameter int ADDR_W = `SRAM_ADDR_W,
	parameter int DATA_W = `SRAM_DATA_W,
	parameter int DEPTH = 1024
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Link to controller
	sram_link_if.mem link,
	// Status
	output logic sleeping,
	output logic wake_window_active
);
	localparam int IDX_W = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || IDX_W > ADDR_W || ADDR_W != `SRAM_ADDR_W || DATA_W != `SRAM_DATA_W)
			$error("sram_mem_end: unsupported parameters");
	end
	logic [DATA_W-1:0] array_mem [DEPTH];
	logic sleep_meta_reg, sleep_sync_reg;
	logic [DATA_W-1:0] q_reg;
	logic q_oe_n_reg;
	logic wr_pend_reg;
	logic [IDX_W-1:0] wr_addr_reg;
	logic [1:0] wake_cnt_reg;
	logic chip_en;
	logic gate_off;
	sram_pkg::cycle_type cyc;
	// Sleep request is caught asynchronously on its rising level, released through a sync
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sleep_meta_reg <= 1'b0;
			sleep_sync_reg <= 1'b0;
		end else begin
			sleep_meta_reg <= link.sleep_request;
			sleep_sync_reg <= sleep_meta_reg;
		end
	end
	// Raw pin gates inputs at once so entry is unclocked; sync copy covers the exit
	assign gate_off = link.sleep_request | sleep_sync_reg;
	assign chip_en = !link.first_chip_select_n && !link.second_chip_select_n
		&& link.third_chip_select;
	// Decode the cycle type at the load edge
	always_comb begin
		cyc = sram_pkg::cyc_idle_unselected;
		if (!gate_off && !link.advance_or_load_strobe_n && chip_en) begin
			if (link.read_write_sel)
				cyc = sram_pkg::cyc_read;
			else
				cyc = sram_pkg::cyc_write;
		end
	end
	// Late write: address now, data next edge; a sleep in between drops it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end else begin
			wr_pend_reg <= (cyc == sram_pkg::cyc_write);
			if (cyc != sram_pkg::cyc_idle_unselected)
				wr_addr_reg <= link.addr[IDX_W-1:0];
		end
	end
	// Array write ignores output enable entirely; lost if sleep arrives first
	always_ff @(posedge sys_clk) begin
		if (wr_pend_reg && !gate_off)
			array_mem[wr_addr_reg] <= link.dq_to_mem;
	end
	// Read data registered and driven; floats in sleep, on writes and on deselected loads; reads take output enable, otherwise holds its enable
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			q_reg <= '0;
			q_oe_n_reg <= 1'b1;
		end else if (gate_off) begin
			q_oe_n_reg <= 1'b1;
		end else if (cyc == sram_pkg::cyc_read) begin
			if (wr_pend_reg && wr_addr_reg == link.addr[IDX_W-1:0])
				q_reg <= link.dq_to_mem; // Coherent with in-flight write
			else
				q_reg <= array_mem[link.addr[IDX_W-1:0]];
			q_oe_n_reg <= link.output_enable_n;
		end else if (cyc == sram_pkg::cyc_idle_unselected && !link.advance_or_load_strobe_n) begin
			q_oe_n_reg <= 1'b1;
		end else if (cyc == sram_pkg::cyc_write) begin
			q_oe_n_reg <= 1'b1;
		end
	end
	assign link.dq_from_mem = q_reg;
	assign link.dq_from_mem_oe_n = q_oe_n_reg;
	// Status flags; sleep tracks pin level only
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sleeping <= 1'b0;
			wake_cnt_reg <= 2'h0;
			wake_window_active <= 1'b0;
		end else begin
			sleeping <= sleep_sync_reg;
			if (sleep_sync_reg)
				wake_cnt_reg <= 2'(`SRAM_WAKE_CYCLES);
			else if (wake_cnt_reg != 2'h0)
				wake_cnt_reg <= wake_cnt_reg - 2'h1;
			wake_window_active <= (wake_cnt_reg != 2'h0) && !sleep_sync_reg;
		end
	end
endmodule : sram_mem_end
`default_nettype wire

//--- sim/sram_link_asserts.sv
// Concurrent checks on the link between controller and memory
`timescale 1ns/100ps
`default_nettype none
module sram_link_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Controller pins
	input wire logic sleep_request,
	input wire logic advance_or_load_strobe_n,
	input wire logic read_write_sel,
	input wire logic first_chip_select_n,
	input wire logic second_chip_select_n,
	input wire logic third_chip_select,
	input wire logic output_enable_n,
	input wire logic dq_to_mem_oe_n,
	// Memory pins
	input wire logic dq_from_mem_oe_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Decoded enable and load terms keep the properties short
	wire logic sel = !first_chip_select_n && !second_chip_select_n && third_chip_select;
	wire logic ld = !advance_or_load_strobe_n && sel;
	sleep_float_a: assert property (sleep_request |=> dq_from_mem_oe_n)
		else $error("data driven while asleep");
	sleep_drain_a: assert property ($rose(sleep_request) |->
		advance_or_load_strobe_n && $past(advance_or_load_strobe_n))
		else $error("sleep raised with a cycle in flight");
	wake_read_only_a: assert property ($fell(sleep_request) |->
		advance_or_load_strobe_n || read_write_sel)
		else $error("write issued while waking");
	write_data_a: assert property (ld && !read_write_sel && !sleep_request |=> !dq_to_mem_oe_n)
		else $error("write data not driven");
	// Reads need sleep low long enough for the exit synchroniser to clear
	read_data_a: assert property ((!sleep_request)[*4] ##0 (ld && read_write_sel) |=>
		output_enable_n || !dq_from_mem_oe_n)
		else $error("read data not driven");
	write_float_a: assert property (ld && !read_write_sel |=> dq_from_mem_oe_n)
		else $error("memory drives during write");
	desel_float_a: assert property (!advance_or_load_strobe_n && !sel |=> dq_from_mem_oe_n)
		else $error("memory drives when deselected");
	wake_float_a: assert property ($fell(sleep_request) |-> dq_from_mem_oe_n [*2])
		else $error("memory drives right after wake");
endmodule : sram_link_asserts
`default_nettype wire

//--- sim/tb.sv
// Bench joining controller and memory ends over the link
`timescale 1ns/100ps
`default_nettype none
`include "sram_cfg.svh"
module tb;
	logic sys_clk = 1'h0;
	logic rstn = 1'h0;
	logic req_valid = 1'h0;
	logic req_write = 1'h0;
	logic [`SRAM_ADDR_W-1:0] req_addr = '0;
	logic [`SRAM_DATA_W-1:0] req_wdata = '0;
	logic sleep_want = 1'h0;
	logic req_ready, rd_valid, sleep_active, sleeping, wake_window_active;
	logic [`SRAM_DATA_W-1:0] rd_data;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	// Free-running system clock
	always #5 sys_clk = ~sys_clk;
	sram_link_if link ();
	sram_mem_end i_sram_mem_end (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.sleeping(sleeping), .wake_window_active(wake_window_active));
	sram_ctrl_end i_sram_ctrl_end (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.sleep_want(sleep_want), .sleep_active(sleep_active), .link(link));
	sram_link_asserts i_sram_link_asserts (.sys_clk(sys_clk), .rstn(rstn),
		.sleep_request(link.sleep_request), .read_write_sel(link.read_write_sel),
		.advance_or_load_strobe_n(link.advance_or_load_strobe_n),
		.first_chip_select_n(link.first_chip_select_n),
		.second_chip_select_n(link.second_chip_select_n),
		.third_chip_select(link.third_chip_select), .output_enable_n(link.output_enable_n),
		.dq_to_mem_oe_n(link.dq_to_mem_oe_n), .dq_from_mem_oe_n(link.dq_from_mem_oe_n));
	// Counts results and prints a line for each miss
	task automatic check(input logic [`SRAM_DATA_W-1:0] seen, input logic [`SRAM_DATA_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Holds the request until the load strobe shows it taken; valid stays up for back to back
	task automatic req(input logic w, input logic [`SRAM_ADDR_W-1:0] a,
		input logic [`SRAM_DATA_W-1:0] d);
		req_valid = 1'h1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		do begin
			@(posedge sys_clk);
			#1;
		end while (link.advance_or_load_strobe_n !== 1'h0);
	endtask : req
	// Reads one word and compares it with the expected value
	task automatic rd(input logic [`SRAM_ADDR_W-1:0] a, input logic [`SRAM_DATA_W-1:0] e);
		req(1'h0, a, '0);
		req_valid = 1'h0;
		do begin
			@(posedge sys_clk);
			#1;
		end while (rd_valid !== 1'h1);
		check(rd_data, e);
		#1;
	endtask : rd
	// Back-to-back writes, one at the top of the array, then read back
	task automatic t_rw;
		req(1'h1, 17'h00005, 36'hA5A5A5A5A);
		req(1'h1, 17'h003FF, 36'hFFFFFFFFF);
		rd(17'h00005, 36'hA5A5A5A5A);
		rd(17'h003FF, 36'hFFFFFFFFF);
	endtask : t_rw
	// Sleep after a write and its read-back, then ask for a write during wake-up
	task automatic t_sleep;
		req(1'h1, 17'h00007, 36'h123456789);
		rd(17'h00007, 36'h123456789);
		sleep_want = 1'h1;
		do @(posedge sys_clk); while (sleep_active !== 1'h1);
		repeat (3) @(posedge sys_clk);
		check(sleeping, 1'h1);
		check(link.dq_from_mem_oe_n, 1'h1);
		check(req_ready, 1'h0);
		#1 sleep_want = 1'h0;
		req(1'h1, 17'h00008, 36'hFEDCBA987);
		req_valid = 1'h0;
		@(posedge sys_clk);
		#1;
		check(sleeping, 1'h0);
		check(wake_window_active, 1'h1);
		rd(17'h00007, 36'h123456789);
		rd(17'h00008, 36'hFEDCBA987);
	endtask : t_sleep
	// Single exit point for the run
	task automatic test_done;
		$display("Checks run %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	// Hang guard, far above the few dozen cycles the tests need
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			test_done();
		end
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		#1 rstn = 1'h1;
		t_rw();
		t_sleep();
		test_done();
	end
endmodule : tb
`default_nettype wire
